/* File: tcs_tx_chan_sel.sv */
// transmit channel selection with apb registers and link-side slot logic
`timescale 1ns/100ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_tx_chan_sel (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [5:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic [31:0] prdata_o,
    output var  logic        pready_o,
    output var  logic        pslverr_o,
    input  wire logic        link_clk_i,
    input  wire logic        frame_start_i,
    input  wire logic        slot_start_i,
    output var  logic        tx_load_o,
    output var  logic        tx_data_oe_o,
    output var  logic [2:0]  tx_current_block_o,
    output var  logic        tx_framesync_source_o,
    output var  logic        rx_framesync_source_o,
    output var  logic        tx_clock_source_o,
    output var  logic        rx_clock_source_o,
    output var  logic        rate_gen_input_select_o,
    output var  logic        tx_framesync_polarity_o,
    output var  logic        rx_framesync_polarity_o,
    output var  logic        tx_clock_edge_o,
    output var  logic        rx_clock_edge_o,
    output var  logic [1:0]  rate_gen_src_o
);
    typedef struct packed {
        tcs_pkg::tcs_mode_t mode;
        logic [1:0]   pa;
        logic [1:0]   pb;
        logic         ext;
        logic [1:0]   rpa;
        logic [1:0]   rpb;
        logic [127:0] txen;
        logic [127:0] rxen;
        logic [11:0]  pin;
        logic         rg_clk;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic         cfg_req;
        logic         ack_s1;
        logic         ack_s2;
        logic         blk_s1;
        logic         blk_s2;
        logic         blk_seen;
        logic [2:0]   cur_blk;
        logic [1:0]   rg_src;
    } tcs_core_t;

    typedef struct packed {
        logic         rst_s1;
        logic         rst_s2;
        logic         req_s1;
        logic         req_s2;
        logic         seen;
        tcs_pkg::tcs_mode_t mode;
        logic [1:0]   pa;
        logic [1:0]   pb;
        logic         ext;
        logic [1:0]   rpa;
        logic [1:0]   rpb;
        logic [127:0] txen;
        logic [127:0] rxen;
        logic [6:0]   cnt;
        logic         load;
        logic         drive;
        logic         en;
        logic         blk_req;
        logic         ack_s1;
        logic         ack_s2;
        logic [2:0]   hold;
    } tcs_link_t;

    tcs_core_t r_reg, r_next;
    tcs_link_t l_reg, l_next;
    logic [6:0] chan_now;
    logic       tx_hit;
    logic       rx_hit;
    logic       acc;

    // channel selected in an enable set, 32- or 128-channel layout
    function automatic logic chan_sel(input logic [127:0] en,
                                      input logic [6:0]   ch,
                                      input logic         ext,
                                      input logic [1:0]   pa,
                                      input logic [1:0]   pb);
        chan_sel = 1'b0;
        if (ext) begin
            chan_sel = en[ch];
        end else if (ch[6:4] == {pa, 1'b0}) begin
            chan_sel = en[{3'h0, ch[3:0]}];
        end else if (ch[6:4] == {pb, 1'b1}) begin
            chan_sel = en[{3'h1, ch[3:0]}];
        end
    endfunction

    // core side: apb slave, config registers, block report capture
    always_comb begin
        r_next = r_reg;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        r_next.ack_s1 = l_reg.seen;
        r_next.ack_s2 = r_reg.ack_s1;
        r_next.blk_s1 = l_reg.blk_req;
        r_next.blk_s2 = r_reg.blk_s1;
        acc = psel_i && penable_i;
        if (r_reg.blk_s2 != r_reg.blk_seen) begin
            r_next.blk_seen = r_reg.blk_s2;
            r_next.cur_blk = l_reg.hold;
        end
        // answer; writes wait while the previous config handoff is open
        if (acc && !r_reg.pready &&
            !(pwrite_i && r_reg.cfg_req != r_reg.ack_s2)) begin
            r_next.pready = 1'b1;
            r_next.prdata = `TCS_RST_VAL;
            case (paddr_i[5:4])
                `TCS_OFS_TXEN: r_next.prdata =
                    r_reg.txen[{paddr_i[3:2], 5'h00} +: 32];
                `TCS_OFS_RXEN: r_next.prdata =
                    r_reg.rxen[{paddr_i[3:2], 5'h00} +: 32];
                default: begin
                    case (paddr_i)
                        `TCS_OFS_CTRL: r_next.prdata = {22'h0,
                            r_reg.ext, r_reg.pb, r_reg.pa,
                            r_reg.cur_blk, r_reg.mode};
                        `TCS_OFS_RXPART: r_next.prdata = {23'h0,
                            r_reg.rpb, r_reg.rpa, 5'h00};
                        `TCS_OFS_PIN: r_next.prdata = {20'h0_0000,
                            r_reg.pin};
                        `TCS_OFS_RATEGEN: r_next.prdata = {31'h0,
                            r_reg.rg_clk};
                        default: r_next.pslverr = 1'b1;
                    endcase
                end
            endcase
        end
        // write takes effect at the edge that samples pready
        if (acc && r_reg.pready && pwrite_i) begin
            r_next.cfg_req = ~r_reg.cfg_req;
            case (paddr_i[5:4])
                `TCS_OFS_TXEN:
                    r_next.txen[{paddr_i[3:2], 5'h00} +: 32] = pwdata_i;
                `TCS_OFS_RXEN:
                    r_next.rxen[{paddr_i[3:2], 5'h00} +: 32] = pwdata_i;
                default: begin
                    case (paddr_i)
                        `TCS_OFS_CTRL: begin
                            r_next.mode = tcs_pkg::tcs_mode_t'(
                                pwdata_i[`TCS_F_MODE]);
                            r_next.pa = pwdata_i[`TCS_F_PA];
                            r_next.pb = pwdata_i[`TCS_F_PB];
                            r_next.ext = pwdata_i[`TCS_F_EXT];
                        end
                        `TCS_OFS_RXPART: begin
                            r_next.rpa = pwdata_i[`TCS_F_PA];
                            r_next.rpb = pwdata_i[`TCS_F_PB];
                        end
                        `TCS_OFS_PIN:
                            r_next.pin = pwdata_i[`TCS_F_PIN];
                        `TCS_OFS_RATEGEN:
                            r_next.rg_clk = pwdata_i[`TCS_F_RG_CLK];
                        default: r_next.cfg_req = r_reg.cfg_req;
                    endcase
                end
            endcase
        end
        r_next.rg_src = {r_reg.pin[7], r_reg.rg_clk};
    end

    // core state register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // link side: config snapshot, slot walk, enable and mask decision
    always_comb begin
        l_next = l_reg;
        l_next.rst_s1 = rst_i;
        l_next.rst_s2 = l_reg.rst_s1;
        l_next.req_s1 = r_reg.cfg_req;
        l_next.req_s2 = l_reg.req_s1;
        l_next.ack_s1 = r_reg.blk_seen;
        l_next.ack_s2 = l_reg.ack_s1;
        l_next.load = 1'b0;
        chan_now = frame_start_i ? 7'h00 : l_reg.cnt + 7'h01;
        // in mode 3 both sets use the rx partition blocks
        tx_hit = (l_reg.mode == tcs_pkg::TCS_SYM) ?
            chan_sel(l_reg.txen, chan_now, l_reg.ext, l_reg.rpa,
                     l_reg.rpb) :
            chan_sel(l_reg.txen, chan_now, l_reg.ext, l_reg.pa, l_reg.pb);
        rx_hit = chan_sel(l_reg.rxen, chan_now, l_reg.ext, l_reg.rpa,
                          l_reg.rpb);
        if (l_reg.req_s2 != l_reg.seen) begin
            l_next.seen = l_reg.req_s2;
            l_next.mode = r_reg.mode;
            l_next.pa = r_reg.pa;
            l_next.pb = r_reg.pb;
            l_next.ext = r_reg.ext;
            l_next.rpa = r_reg.rpa;
            l_next.rpb = r_reg.rpb;
            l_next.txen = r_reg.txen;
            l_next.rxen = r_reg.rxen;
        end
        if (slot_start_i) begin
            l_next.cnt = chan_now;
            case (l_reg.mode)
                tcs_pkg::TCS_ALL: begin
                    l_next.en = 1'b1;
                    l_next.drive = 1'b1;
                end
                tcs_pkg::TCS_TXSEL: begin
                    l_next.en = tx_hit;
                    l_next.drive = tx_hit;
                end
                tcs_pkg::TCS_MASK: begin
                    l_next.en = 1'b1;
                    l_next.drive = tx_hit;
                end
                tcs_pkg::TCS_SYM: begin
                    l_next.en = rx_hit;
                    l_next.drive = rx_hit && tx_hit;
                end
                default: begin
                    l_next.en = 1'b0;
                    l_next.drive = 1'b0;
                end
            endcase
            l_next.load = l_next.en;
        end
        // hand the active block to the core once the last one is taken
        if (l_reg.cnt[6:4] != l_reg.hold &&
            l_reg.blk_req == l_reg.ack_s2) begin
            l_next.hold = l_reg.cnt[6:4];
            l_next.blk_req = ~l_reg.blk_req;
        end
        if (l_reg.rst_s2) begin
            l_next = '0;
            l_next.rst_s1 = rst_i;
            l_next.rst_s2 = l_reg.rst_s1;
        end
    end

    // link state register
    always_ff @(posedge link_clk_i) begin
        l_reg <= l_next;
    end

    // outputs straight from state
    assign prdata_o = r_reg.prdata;
    assign pready_o = r_reg.pready;
    assign pslverr_o = r_reg.pslverr;
    assign tx_load_o = l_reg.load;
    assign tx_data_oe_o = l_reg.drive;
    assign tx_current_block_o = r_reg.cur_blk;
    assign tx_framesync_source_o = r_reg.pin[11];
    assign rx_framesync_source_o = r_reg.pin[10];
    assign tx_clock_source_o = r_reg.pin[9];
    assign rx_clock_source_o = r_reg.pin[8];
    assign rate_gen_input_select_o = r_reg.pin[7];
    assign tx_framesync_polarity_o = r_reg.pin[3];
    assign rx_framesync_polarity_o = r_reg.pin[2];
    assign tx_clock_edge_o = r_reg.pin[1];
    assign rx_clock_edge_o = r_reg.pin[0];
    assign rate_gen_src_o = r_reg.rg_src;

    // checks on the link side
    a_all_chan_on: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        slot_start_i && l_reg.mode == tcs_pkg::TCS_ALL
        |=> tx_load_o && tx_data_oe_o)
        else $error("mode 0 slot not loaded and driven");
    a_txsel_gate: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        slot_start_i && l_reg.mode == tcs_pkg::TCS_TXSEL
        |=> tx_load_o == $past(tx_hit) && tx_data_oe_o == tx_load_o)
        else $error("mode 1 slot does not follow tx enables");
    a_mask_mode: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        slot_start_i && l_reg.mode == tcs_pkg::TCS_MASK
        |=> tx_load_o && tx_data_oe_o == $past(tx_hit))
        else $error("mode 2 slot mask wrong");
    a_sym_mode: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        slot_start_i && l_reg.mode == tcs_pkg::TCS_SYM
        |=> tx_load_o == $past(rx_hit)
            && tx_data_oe_o == ($past(rx_hit) && $past(tx_hit)))
        else $error("mode 3 slot enable or mask wrong");
    a_ext_range: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        slot_start_i && l_reg.ext && l_reg.mode == tcs_pkg::TCS_TXSEL
        |=> tx_load_o == $past(l_reg.txen[chan_now]))
        else $error("128-channel select wrong");
    a_part_out: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        slot_start_i && !l_reg.ext && l_reg.mode == tcs_pkg::TCS_TXSEL
        && chan_now[6:4] != {l_reg.pa, 1'b0}
        && chan_now[6:4] != {l_reg.pb, 1'b1}
        |=> !tx_load_o)
        else $error("channel outside partitions was loaded");
    a_drive_loaded: assert property (@(posedge link_clk_i)
        disable iff (l_reg.rst_s2)
        $rose(tx_data_oe_o) |-> tx_load_o)
        else $error("data driven in a slot with no word loaded");
    // checks on the core side
    a_mode_write: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        psel_i && penable_i && pready_o && pwrite_i
        && paddr_i == `TCS_OFS_CTRL
        |=> r_reg.mode == $past(pwdata_i[1:0]))
        else $error("mode field not written");
    a_blk_report: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $changed(tx_current_block_o) |-> tx_current_block_o == l_reg.hold)
        else $error("current block differs from link report");
    a_pready_pulse: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    c_sym_load: cover property (@(posedge link_clk_i)
        l_reg.mode == tcs_pkg::TCS_SYM && tx_load_o && !tx_data_oe_o);
    c_part_b: cover property (@(posedge link_clk_i)
        !l_reg.ext && tx_load_o && l_reg.cnt[4] && l_reg.mode != 2'h0);
    c_block7: cover property (@(posedge core_clk_i)
        tx_current_block_o == 3'h7);
endmodule
`default_nettype wire

/* File: tcs_regs.svh */
// register offsets, fields, reset values of the transmit channel selector
// Overview of operation
// - a read-only field reports the 16-channel block now being sent
// - block n reads as value n and covers channels 16n to 16n+15
// - a two-bit field at bits 1-0 sets the channel select mode
// - mode 0: every channel is enabled and unmasked, enables ignored
// - mode 1: unselected channels disabled, selected ones unmasked
// - mode 2: all channels enabled, unselected ones masked
// - mode 3: enabled by rx enables, masked unless also tx selected
// - mode 3 takes partition blocks from the rx partition fields
// - range extend picks 32 or all 128 channels as selectable
// - partition A holds an even block, B an odd one, changeable live
// - software picks fsync and clock source per direction
// - software picks fsync polarity and sampling edge per direction
// - rate generator input from pin control bit and config bit
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_OFS_CTRL    6'h00
`define TCS_OFS_RXPART  6'h04
`define TCS_OFS_PIN     6'h08
`define TCS_OFS_RATEGEN 6'h0C
`define TCS_OFS_TXEN    2'h1
`define TCS_OFS_RXEN    2'h2
`define TCS_F_MODE      1:0
`define TCS_F_CURBLK    4:2
`define TCS_F_PA        6:5
`define TCS_F_PB        8:7
`define TCS_F_EXT       9
`define TCS_F_PIN       11:0
`define TCS_F_RG_CLK    0
`define TCS_RST_VAL     32'h0000_0000
`endif

/* File: tcs_pkg.sv */
// types of the transmit channel selector
package tcs_pkg;
    typedef enum logic [1:0] {
        TCS_ALL,
        TCS_TXSEL,
        TCS_MASK,
        TCS_SYM
    } tcs_mode_t;
endpackage

/* File: tcs_slot_partner.sv */
// far-side slot source that frames channels and samples each answer
`timescale 1ns/100ps
`default_nettype none
module tcs_slot_partner (
    input  wire logic       link_clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] nslots_i,
    input  wire logic       tx_load_i,
    input  wire logic       tx_data_oe_i,
    output var  logic       frame_start_o,
    output var  logic       slot_start_o,
    output var  logic       seen_o,
    output var  logic [6:0] ch_o,
    output var  logic       load_o,
    output var  logic       oe_o,
    output var  logic       busy_o
);
    // one frame of nslots slots, three link cycles per slot
    initial begin
        frame_start_o = 0;
        slot_start_o = 0;
        seen_o = 0;
        ch_o = 0;
        load_o = 0;
        oe_o = 0;
        busy_o = 0;
        forever begin
            @(posedge link_clk_i);
            if (go_i) begin
                busy_o <= 1;
                for (int i = 0; i < nslots_i; i++) begin
                    frame_start_o <= (i == 0);
                    slot_start_o <= 1;
                    @(posedge link_clk_i);
                    slot_start_o <= 0;
                    frame_start_o <= 0;
                    @(posedge link_clk_i);
                    // undriven slots show as oe low to the far side
                    seen_o <= 1;
                    ch_o <= 7'(i);
                    load_o <= tx_load_i;
                    oe_o <= tx_data_oe_i;
                    @(posedge link_clk_i);
                    seen_o <= 0;
                end
                busy_o <= 0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// bench for the transmit channel selector: apb config, slots, pin fields
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        core_clk_i = 0, link_clk_i = 0, rst_i = 1;
    logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [5:0]  paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o;
    logic        pready_o, pslverr_o, frame_start_i, slot_start_i;
    logic        tx_load_o, tx_data_oe_o;
    logic [2:0]  tx_current_block_o;
    logic [1:0]  rate_gen_src_o;
    logic        tx_framesync_source_o, rx_framesync_source_o;
    logic        tx_clock_source_o, rx_clock_source_o;
    logic        rate_gen_input_select_o, tx_framesync_polarity_o;
    logic        rx_framesync_polarity_o, tx_clock_edge_o, rx_clock_edge_o;
    logic        go = 0, seen, busy, s_load, s_oe, err;
    logic [6:0]  s_ch;
    logic [7:0]  nslots = 0;
    logic [31:0] seed = 32'hedd1_a77e, rd, txen [4], rxen [4];
    int          num_errors = 0, checks = 0, mode, ext, pa, pb, lastblk;

    initial forever #12.5 core_clk_i = ~core_clk_i;
    initial begin
        #7;
        forever #15 link_clk_i = ~link_clk_i;
    end

    tcs_tx_chan_sel DUT (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link_clk_i,
        .frame_start_i, .slot_start_i, .tx_load_o, .tx_data_oe_o,
        .tx_current_block_o, .tx_framesync_source_o, .rx_framesync_source_o,
        .tx_clock_source_o, .rx_clock_source_o, .rate_gen_input_select_o,
        .tx_framesync_polarity_o, .rx_framesync_polarity_o, .tx_clock_edge_o,
        .rx_clock_edge_o, .rate_gen_src_o);

    tcs_slot_partner PART (.link_clk_i(link_clk_i), .go_i(go),
        .nslots_i(nslots), .tx_load_i(tx_load_o), .tx_data_oe_i(tx_data_oe_o),
        .frame_start_o(frame_start_i), .slot_start_o(slot_start_i),
        .seen_o(seen), .ch_o(s_ch), .load_o(s_load), .oe_o(s_oe),
        .busy_o(busy));

    // xorshift source of random values
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic limit(input int i, input int n);
        if (i >= n) begin
            num_errors++;
            complete_run();
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int i;
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge core_clk_i);
            if (pready_o === 1'h1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        limit(i, 60);
        psel_i <= 0;
        penable_i <= 0;
        @(posedge core_clk_i);
    endtask

    // selection model: which enable bit stands for a channel
    function automatic bit pick(input logic [31:0] en [4], input int ch);
        if (ext) return en[ch/32][ch%32];
        if (ch / 16 == 2 * pa) return en[0][ch%16];
        if (ch / 16 == 2 * pb + 1) return en[0][16+ch%16];
        return 0;
    endfunction

    // expected {load, drive} of a slot
    function automatic logic [1:0] exp_slot(input int ch);
        bit t, r;
        t = pick(txen, ch);
        r = pick(rxen, ch);
        case (mode)
            0: return 2'h3;
            1: return {t, t};
            2: return {1'h1, t};
            default: return {r, r & t};
        endcase
    endfunction

    // compare every sampled slot with the model
    always @(posedge link_clk_i) begin
        if (seen === 1'h1)
            check({s_load, s_oe}, exp_slot(s_ch));
    end

    task automatic setup_cfg(input int m, input int e);
        int tpa, tpb, rpa, rpb, k;
        logic [31:0] c;
        mode = m;
        ext = e;
        tpa = rnd() % 4;
        tpb = rnd() % 4;
        rpa = rnd() % 4;
        rpb = rnd() % 4;
        pa = (m == 3) ? rpa : tpa;
        pb = (m == 3) ? rpb : tpb;
        c = m | tpa << 5 | tpb << 7 | e << 9 | 32'hffff_fc1c;
        apb(1, 6'h00, c);
        apb(1, 6'h04, rpa << 5 | rpb << 7);
        for (k = 0; k < 4; k++) begin
            txen[k] = rnd();
            rxen[k] = rnd();
            apb(1, 6'h10 + 6'(4 * k), txen[k]);
            apb(1, 6'h20 + 6'(4 * k), rxen[k]);
        end
        apb(0, 6'h00, 0);
        check(rd, (c & 32'h0000_03e3) | lastblk << 2);
        apb(0, 6'h1c, 0);
        check(rd, txen[3]);
        apb(0, 6'h04, 0);
        check(rd, rpa << 5 | rpb << 7);
    endtask

    task automatic run_frame(input int n);
        int i;
        nslots <= 8'(n);
        repeat (12) @(posedge link_clk_i);
        @(posedge core_clk_i);
        go <= 1;
        for (i = 0; i < 100 && busy !== 1'h1; i++) @(posedge core_clk_i);
        go <= 0;
        limit(i, 100);
        for (i = 0; i < 2000 && busy !== 1'h0; i++) @(posedge core_clk_i);
        limit(i, 2000);
        repeat (12) @(posedge core_clk_i);
        lastblk = (n - 1) / 16;
        check(tx_current_block_o, lastblk);
    endtask

    initial begin
        logic [31:0] p, q;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 0;
        lastblk = 0;
        apb(0, 6'h00, 0);
        check(rd, 0);
        check({tx_current_block_o, rate_gen_src_o}, 0);
        apb(0, 6'h30, 0);
        check(err, 1);
        check(rd, 0);
        // random pin and rate-generator fields, pin field read back, both checked at the ports
        repeat (3) begin
            p = rnd();
            q = rnd();
            apb(1, 6'h08, p);
            apb(1, 6'h0c, q);
            apb(0, 6'h08, 0);
            check(rd, p & 32'h0000_0fff);
            check({tx_framesync_source_o, rx_framesync_source_o,
                   tx_clock_source_o, rx_clock_source_o,
                   rate_gen_input_select_o, tx_framesync_polarity_o,
                   rx_framesync_polarity_o, tx_clock_edge_o,
                   rx_clock_edge_o}, {p[11:7], p[3:0]});
            check(rate_gen_src_o, {p[7], q[0]});
        end
        // every mode with both channel ranges
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                setup_cfg(m, e);
                run_frame(e ? 128 : 1 + rnd() % 128);
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
